// *** rtl/ovrb_regs.vh ***
`ifndef OVRB_REGS_VH
`define OVRB_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define OVRB_IDX_PHONES_LEFT 8'h39
`define OVRB_IDX_PHONES_RIGHT 8'h3A
`define OVRB_IDX_LINE_LEFT 8'h3B
`define OVRB_IDX_LINE_RIGHT 8'h3C
`define OVRB_IDX_PENDING_STATUS 8'h3D

// Field positions inside each channel register.
`define OVRB_BIT_SILENCE 8
`define OVRB_BIT_COMMIT 7
`define OVRB_BIT_ZC_GATE 6
`define OVRB_GAIN_MSB 5
`define OVRB_GAIN_LSB 0
`define OVRB_GAIN_W 6

// Reset values.
`define OVRB_RST_SILENCE 1'b0
`define OVRB_RST_ZC_GATE 1'b0
`define OVRB_RST_PHONES_GAIN 6'h2D
`define OVRB_RST_LINE_GAIN 6'h39

// Gain code that stands for 0 dB; each code step is 1 dB.
`define OVRB_GAIN_ZERO_DB 6'h39

`endif

// *** rtl/ovrb_top.v ***
// Function
// - Phones bit 8 mutes channel, resets unmuted.
// - Line bit 8 mutes channel, resets zero.
// - Phones commit bit applies both gains together when neither has zero-cross gating on.
// - Line commit bit applies both gains together when neither has zero-cross gating on.
// - Phones commit bit 7 both registers, reads zero.
// - Line commit bit 7 both registers, reads zero.
// - Phones bit 6 enables zero-cross gating, reset off.
// - Line bit 6 enables zero-cross gating, reset off.
// - Phones gain 1 dB steps, 0x39 is 0 dB.
// - Line gain same 1 dB coding, 0x39 0 dB.
// - Phones gain resets to code 0x2D.
// - Line gain resets to code 0x39.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "ovrb_regs.vh"

module ovrb_top (
    // Clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // Avalon-MM slave, byte addressed
    input wire [9:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output wire [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // Zero-crossing pulses from each output path
    input wire phones_left_zero_cross_in,
    input wire phones_right_zero_cross_in,
    input wire line_left_zero_cross_in,
    input wire line_right_zero_cross_in,
    // Active gain codes
    output wire [5:0] phones_left_gain_out,
    output wire [5:0] phones_right_gain_out,
    output wire [5:0] line_left_gain_out,
    output wire [5:0] line_right_gain_out,
    // Channel mutes
    output wire phones_left_silence_out,
    output wire phones_right_silence_out,
    output wire line_left_silence_out,
    output wire line_right_silence_out
);

    localparam NCH = 4;
    localparam GW = `OVRB_GAIN_W;

    reg waitrequest_reg;
    reg [31:0] readdata_reg;

    // Per-channel state, channel order: phones left, phones right, line left, line right.
    reg [NCH-1:0] silence_reg;
    reg [NCH-1:0] zc_gate_reg;
    reg [NCH-1:0] pending_reg;
    reg [GW*NCH-1:0] staged_reg;
    reg [GW*NCH-1:0] held_reg;
    reg [GW*NCH-1:0] active_reg;

    wire [NCH-1:0] zero_cross;
    wire [NCH-1:0] ch_hit;
    wire status_hit;
    wire wr_take;
    wire rd_take;
    wire low_lane;
    wire high_lane;
    wire phones_commit;
    wire line_commit;
    wire [NCH-1:0] ch_commit;
    reg [31:0] readdata_next;

    assign zero_cross = {line_right_zero_cross_in, line_left_zero_cross_in,
                         phones_right_zero_cross_in, phones_left_zero_cross_in};

    // Registers sit at four times their index.
    assign ch_hit[0] = (avs_address_in == {`OVRB_IDX_PHONES_LEFT, 2'b00});
    assign ch_hit[1] = (avs_address_in == {`OVRB_IDX_PHONES_RIGHT, 2'b00});
    assign ch_hit[2] = (avs_address_in == {`OVRB_IDX_LINE_LEFT, 2'b00});
    assign ch_hit[3] = (avs_address_in == {`OVRB_IDX_LINE_RIGHT, 2'b00});
    assign status_hit = (avs_address_in == {`OVRB_IDX_PENDING_STATUS, 2'b00});

    // A request completes on the edge where waitrequest is seen low.
    assign wr_take = avs_write_in & ~waitrequest_reg;
    assign rd_take = avs_read_in & ~waitrequest_reg;
    assign low_lane = avs_byteenable_in[0];
    assign high_lane = avs_byteenable_in[1];

    // The commit bit is shared by both registers of a pair and is never stored.
    assign phones_commit = wr_take & low_lane & (ch_hit[0] | ch_hit[1]) &
                           avs_writedata_in[`OVRB_BIT_COMMIT];
    assign line_commit = wr_take & low_lane & (ch_hit[2] | ch_hit[3]) &
                         avs_writedata_in[`OVRB_BIT_COMMIT];
    assign ch_commit = {line_commit, line_commit, phones_commit, phones_commit};

    // Bus handshake: one wait cycle, then a single acknowledge cycle.
    always @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            waitrequest_reg <= 1'b1;
            readdata_reg <= 32'h00000000;
        end
        else
        begin
            if (waitrequest_reg && (avs_read_in || avs_write_in))
            begin
                waitrequest_reg <= 1'b0;
                readdata_reg <= readdata_next;
            end
            else
            begin
                waitrequest_reg <= 1'b1;
            end
        end
    end

    // Readback shows staged gains; the commit bit always reads zero.
    always @*
    begin
        readdata_next = 32'h00000000;
        if (ch_hit[0])
        begin
            readdata_next[8:0] = {silence_reg[0], 1'b0, zc_gate_reg[0], staged_reg[5:0]};
        end
        else if (ch_hit[1])
        begin
            readdata_next[8:0] = {silence_reg[1], 1'b0, zc_gate_reg[1], staged_reg[11:6]};
        end
        else if (ch_hit[2])
        begin
            readdata_next[8:0] = {silence_reg[2], 1'b0, zc_gate_reg[2], staged_reg[17:12]};
        end
        else if (ch_hit[3])
        begin
            readdata_next[8:0] = {silence_reg[3], 1'b0, zc_gate_reg[3], staged_reg[23:18]};
        end
        else if (status_hit)
        begin
            readdata_next[3:0] = pending_reg;
        end
        else
        begin
            readdata_next = 32'h00000000;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1)
        begin : g_ch
            // Phones and line differ only in their gain reset code.
            localparam [GW-1:0] GAIN_RST = (i < 2) ? `OVRB_RST_PHONES_GAIN :
                                                     `OVRB_RST_LINE_GAIN;
            wire hit_wr;
            wire [GW-1:0] staged_next;
            wire gate_next;

            assign hit_wr = wr_take & ch_hit[i];
            // A write that commits uses the gain carried in that same write.
            assign staged_next = (hit_wr && low_lane) ?
                avs_writedata_in[`OVRB_GAIN_MSB:`OVRB_GAIN_LSB] :
                staged_reg[GW*i +: GW];
            assign gate_next = (hit_wr && low_lane) ?
                avs_writedata_in[`OVRB_BIT_ZC_GATE] : zc_gate_reg[i];

            always @(posedge ref_clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    silence_reg[i] <= `OVRB_RST_SILENCE;
                    zc_gate_reg[i] <= `OVRB_RST_ZC_GATE;
                    staged_reg[GW*i +: GW] <= GAIN_RST;
                    held_reg[GW*i +: GW] <= GAIN_RST;
                    active_reg[GW*i +: GW] <= GAIN_RST;
                    pending_reg[i] <= 1'b0;
                end
                else
                begin
                    if (hit_wr && high_lane)
                    begin
                        silence_reg[i] <= avs_writedata_in[`OVRB_BIT_SILENCE];
                    end
                    zc_gate_reg[i] <= gate_next;
                    staged_reg[GW*i +: GW] <= staged_next;
                    if (ch_commit[i])
                    begin
                        // Both channels of the pair are committed on the same edge.
                        if (gate_next)
                        begin
                            held_reg[GW*i +: GW] <= staged_next;
                            pending_reg[i] <= 1'b1;
                        end
                        else
                        begin
                            active_reg[GW*i +: GW] <= staged_next;
                            pending_reg[i] <= 1'b0;
                        end
                    end
                    else if (pending_reg[i] && (zero_cross[i] || !zc_gate_reg[i]))
                    begin
                        // Turning the gate off releases a waiting change on the edge after the gate bit clears,
                        // so a silent input can never strand it.
                        active_reg[GW*i +: GW] <= held_reg[GW*i +: GW];
                        pending_reg[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Gain codes pass through unchanged; 0x39 is 0 dB at 1 dB per code.
    assign phones_left_gain_out = active_reg[5:0];
    assign phones_right_gain_out = active_reg[11:6];
    assign line_left_gain_out = active_reg[17:12];
    assign line_right_gain_out = active_reg[23:18];
    assign phones_left_silence_out = silence_reg[0];
    assign phones_right_silence_out = silence_reg[1];
    assign line_left_silence_out = silence_reg[2];
    assign line_right_silence_out = silence_reg[3];
    assign avs_readdata_out = readdata_reg;
    assign avs_waitrequest_out = waitrequest_reg;

endmodule // ovrb_top

// *** tb/output_volume_register_bank_bench.sv ***
`timescale 1ns/1ps
module output_volume_register_bank_bench;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [9:0] avs_address_in = 10'h000;
    logic [31:0] avs_writedata_in = 32'h00000000;
    logic [3:0] avs_byteenable_in = 4'h0;
    logic [3:0] zc = 4'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [5:0] g [4];
    logic [3:0] mute;
    logic [31:0] q;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    ovrb_top dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .phones_left_zero_cross_in(zc[3]), .phones_right_zero_cross_in(zc[2]),
        .line_left_zero_cross_in(zc[1]), .line_right_zero_cross_in(zc[0]),
        .phones_left_gain_out(g[0]), .phones_right_gain_out(g[1]),
        .line_left_gain_out(g[2]), .line_right_gain_out(g[3]),
        .phones_left_silence_out(mute[3]), .phones_right_silence_out(mute[2]),
        .line_left_silence_out(mute[1]), .line_right_silence_out(mute[0]));
    always #5 ref_clk_in = ~ref_clk_in;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // The request is held until waitrequest is seen low, then dropped with one idle edge.
    task automatic bus(input logic w, input logic [9:0] a, input logic [8:0] d,
        input logic [3:0] be, output logic [31:0] r);
        avs_address_in <= a;
        avs_writedata_in <= {23'h000000, d};
        avs_byteenable_in <= be;
        avs_write_in <= w;
        avs_read_in <= !w;
        @(posedge ref_clk_in);
        while (avs_waitrequest_out !== 1'b0) @(posedge ref_clk_in);
        r = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, 10'h0E4 + 10'(4 * i), 9'h000, 4'hF, q);
            chk(q, (i < 2) ? 32'h0000002D : 32'h00000039);
            chk(32'(g[i]), (i < 2) ? 32'h0000002D : 32'h00000039);
        end
        chk(32'(mute), 32'h00000000);
    endtask
    task automatic t_commit();
        bus(1'b1, 10'h0E4, 9'h000, 4'h1, q);
        chk(32'(g[0]), 32'h0000002D);
        bus(1'b1, 10'h0E8, 9'h0BF, 4'h1, q);
        chk(32'({g[0], g[1]}), 32'h0000003F);
        bus(1'b0, 10'h0E8, 9'h000, 4'hF, q);
        chk(q, 32'h0000003F);
        bus(1'b1, 10'h0F0, 9'h001, 4'h1, q);
        bus(1'b1, 10'h0EC, 9'h0AA, 4'h1, q);
        chk(32'({g[2], g[3]}), 32'h00000A81);
        bus(1'b0, 10'h0EC, 9'h000, 4'hF, q);
        chk(q, 32'h0000002A);
    endtask
    task automatic t_mute();
        bus(1'b1, 10'h0E4, 9'h100, 4'h2, q);
        bus(1'b1, 10'h0F0, 9'h1FF, 4'h2, q);
        chk(32'(mute), 32'h00000009);
        chk(32'(g[3]), 32'h00000001);
        bus(1'b0, 10'h0F0, 9'h000, 4'hF, q);
        chk(q, 32'h00000101);
    endtask
    task automatic t_gate();
        bus(1'b1, 10'h0E4, 9'h0D0, 4'h1, q);
        bus(1'b1, 10'h0EC, 9'h0C5, 4'h1, q);
        chk(32'({g[0], g[2]}), 32'h0000002A);
        // Pending bits run phones left in bit 0 up to line right in bit 3.
        bus(1'b0, 10'h0F4, 9'h000, 4'hF, q);
        chk(q, 32'h00000005);
        zc <= 4'hA;
        @(posedge ref_clk_in);
        zc <= 4'h0;
        @(posedge ref_clk_in);
        chk(32'({g[0], g[2]}), 32'h00000405);
    endtask
    task automatic t_unmapped();
        bus(1'b1, 10'h000, 9'h1FF, 4'hF, q);
        bus(1'b0, 10'h000, 9'h000, 4'hF, q);
        chk(q, 32'h00000000);
        chk(32'({g[0], g[1]}), 32'h0000043F);
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        @(posedge ref_clk_in);
        t_reset();
        t_commit();
        t_mute();
        t_gate();
        t_unmapped();
        end_sim();
    end
endmodule // output_volume_register_bank_bench

// *** tb/ovrb_props.sv ***
`timescale 1ns/1ps
module ovrb_props (
    input wire logic ref_clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out,
    input wire logic [9:0] avs_address_in,
    input wire logic [31:0] avs_writedata_in, avs_readdata_out,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic phones_left_zero_cross_in, phones_left_silence_out, line_right_silence_out,
    input wire logic [5:0] phones_left_gain_out, phones_right_gain_out, line_left_gain_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);
    wire acc = avs_write_in && !avs_waitrequest_out;
    wire [9:0] a = avs_address_in;
    wire [8:0] d = avs_writedata_in[8:0];
    wire lane0_commit = avs_byteenable_in[0] && d[7] && !d[6];
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence
    a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("request not answered after one wait");
    a_wait_single: assert property (s_req |=> avs_waitrequest_out)
        else $error("wait released for more than one cycle");
    a_phones_mute: assert property (acc && a == 10'h0E4 && avs_byteenable_in[1]
        |=> phones_left_silence_out == $past(d[8])) else $error("phones mute wrong");
    a_line_mute: assert property (acc && a == 10'h0F0 && avs_byteenable_in[1]
        |=> line_right_silence_out == $past(d[8])) else $error("line mute wrong");
    a_phones_commit: assert property (acc && a == 10'h0E8 && lane0_commit
        |=> phones_right_gain_out == $past(d[5:0])) else $error("phones commit wrong");
    a_line_commit: assert property (acc && a == 10'h0EC && lane0_commit
        |=> line_left_gain_out == $past(d[5:0])) else $error("line commit wrong");
    a_gain_cause: assert property ($changed(phones_left_gain_out)
        |-> $past(acc) || $past(acc, 2) || $past(phones_left_zero_cross_in))
        else $error("gain changed without cause");
    a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out && a == 10'h000
        |-> avs_readdata_out == 32'h00000000) else $error("unmapped read not zero");
endmodule // ovrb_props
bind ovrb_top ovrb_props u_props (.*);
